// ==== hw/tx_search_pkg.sv ====
// constants, state and struct types of the transmit power search controller
package tx_search_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_HZ = 2500;
  localparam int unsigned STARTUP_HALF_CYCLES = CLK_HZ / (2 * STARTUP_HZ);
  localparam int unsigned DEFAULT_DELAY_MS = 20;
  localparam int unsigned DEFAULT_DELAY_US = DEFAULT_DELAY_MS * 1000;
  localparam int unsigned SETTLE_MIN_MS = 1;
  localparam int unsigned SETTLE_MAX_MS = 20;

  ////////////////////////////////////////////////////////////////////////////
  // search steps, in 1/32 of the tank period
  localparam logic [4:0] FIRST_STEP = 5'h01;
  localparam logic [4:0] MAX_STEP = 5'h10;
  localparam logic [7:0] DEFAULT_STEP_THR = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses) and reset values
  localparam logic [7:0] OFS_SETTLE = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_SEARCH = 8'h08;
  localparam logic [7:0] OFS_FREQ = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [15:0] RST_SETTLE_US = 16'(SETTLE_MIN_MS * 1000);
  localparam logic [23:0] RST_DELAY_US = 24'h0F4240;
  localparam logic [4:0] RST_MIN_STEP = 5'h02;
  localparam logic [7:0] RST_STEP_THR = 8'h10;
  localparam logic [15:0] RST_FREQ_LIMIT = 16'h00FA;
  // search config fields
  localparam int unsigned MIN_STEP_LSB = 0;
  localparam int unsigned STEP_THR_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised comparator pins
  localparam int unsigned NPINS = 13;
  localparam int unsigned P_ITH = 0;
  localparam int unsigned P_ILIM = 1;
  localparam int unsigned P_CURRENT_MONITOR_LEVEL_GND = 2;
  localparam int unsigned P_HOT = 3;
  localparam int unsigned P_NTC_OPEN = 4;
  localparam int unsigned P_DIS = 5;
  localparam int unsigned P_SETTLE_HI = 6;
  localparam int unsigned P_DLY_GND = 7;
  localparam int unsigned P_DLY_OPEN = 8;
  localparam int unsigned P_FB_GND = 9;
  localparam int unsigned P_PWM_GND = 10;
  localparam int unsigned P_THR_HI = 11;
  localparam int unsigned P_DIR = 12;

  typedef enum logic [1:0] {st_off, st_search, st_hold, st_rest} state_e;

  typedef struct packed {
    logic [NPINS-1:0] sync1;
    logic [NPINS-1:0] sync2;
    logic ack;
    logic [31:0] dat;
    logic [15:0] settle_us;
    logic [23:0] delay_us;
    logic [4:0] min_step;
    logic [7:0] step_thr;
    logic [15:0] freq_limit;
    state_e state;
    logic [4:0] step;
    logic [7:0] prev_fb;
    logic fb_valid;
    logic [6:0] us_cnt;
    logic [23:0] tmr;
    logic [15:0] half_cnt;
    logic [15:0] half_period;
    logic locked;
    logic dir_prev;
    logic [15:0] su_cnt;
    logic sq;
    logic [16:0] pw_cnt;
    logic node_a;
    logic node_b;
    logic freq_fault;
    logic no_rx;
    logic ilim_flag;
    logic stat_on;
  } ctrl_s;

endpackage

// ==== hw/tx_search_ctrl.sv ====
// transmit power search controller with wishbone register slave
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module tx_search_ctrl #(
  parameter int unsigned STARTUP_HALF = tx_search_pkg::STARTUP_HALF_CYCLES,
  parameter int unsigned DEFAULT_DELAY = tx_search_pkg::DEFAULT_DELAY_US
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic search_current_threshold_i,
  input wire logic delay_current_limit_i,
  input wire logic current_monitor_grounded_i,
  input wire logic thermistor_hot_i,
  input wire logic thermistor_open_i,
  input wire logic disable_i,
  input wire logic settle_cap_tied_high_i,
  input wire logic search_delay_cap_grounded_i,
  input wire logic search_delay_cap_open_i,
  input wire logic tank_feedback_grounded_i,
  input wire logic min_pulse_width_grounded_i,
  input wire logic feedback_step_tied_high_i,
  input wire logic tank_current_dir_i,
  input wire logic [7:0] tank_feedback_i,
  output logic switch_node_a_o,
  output logic switch_node_b_o,
  output logic status_o,
  output logic status_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state and derived terms

  tx_search_pkg::ctrl_s cur;
  tx_search_pkg::ctrl_s next_cur;

  logic [tx_search_pkg::NPINS-1:0] pins;
  logic [tx_search_pkg::NPINS-1:0] s;
  logic disabled;
  logic hot_eff;
  logic ith_eff;
  logic ilim_eff;
  logic dir;
  logic dir_edge;
  logic drive_en;
  logic tick;
  logic settle_done;
  logic delay_done;
  logic [23:0] delay_target;
  logic [7:0] fb_delta;
  logic [7:0] step_thr_eff;
  logic [4:0] first_step;
  logic fb_exit;
  logic freq_fault_now;
  logic [20:0] prod;
  logic [16:0] thr_a;
  logic [16:0] thr_b;
  logic [31:0] settle_wr;
  logic [31:0] delay_wr;
  logic [31:0] freq_wr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign pins = {tank_current_dir_i, feedback_step_tied_high_i, min_pulse_width_grounded_i,
                 tank_feedback_grounded_i, search_delay_cap_open_i,
                 search_delay_cap_grounded_i, settle_cap_tied_high_i, disable_i,
                 thermistor_open_i, thermistor_hot_i, current_monitor_grounded_i,
                 delay_current_limit_i, search_current_threshold_i};
  assign s = cur.sync2;
  assign settle_wr = merge({16'h0000, cur.settle_us}, wb_dat_i, wb_sel_i);
  assign delay_wr = merge({8'h00, cur.delay_us}, wb_dat_i, wb_sel_i);
  assign freq_wr = merge({16'h0000, cur.freq_limit}, wb_dat_i, wb_sel_i);

  assign disabled = s[tx_search_pkg::P_DIS] | s[tx_search_pkg::P_SETTLE_HI];
  assign hot_eff = s[tx_search_pkg::P_HOT] & ~s[tx_search_pkg::P_NTC_OPEN];
  assign ith_eff = s[tx_search_pkg::P_ITH] & ~s[tx_search_pkg::P_CURRENT_MONITOR_LEVEL_GND];
  assign ilim_eff = s[tx_search_pkg::P_ILIM] & ~s[tx_search_pkg::P_CURRENT_MONITOR_LEVEL_GND];
  assign dir = s[tx_search_pkg::P_DIR];
  assign dir_edge = dir ^ cur.dir_prev;
  assign drive_en = ~disabled & ~hot_eff &
                    (cur.state == tx_search_pkg::st_search || cur.state == tx_search_pkg::st_hold);
  assign tick = (cur.us_cnt == 7'(tx_search_pkg::US_CYCLES - 1));
  assign settle_done = (cur.tmr >= {8'h00, cur.settle_us});
  // open delay pin falls back to the short default
  assign delay_target = s[tx_search_pkg::P_DLY_OPEN] ? 24'(DEFAULT_DELAY) : cur.delay_us;
  assign delay_done = (cur.tmr >= delay_target) & ~s[tx_search_pkg::P_DLY_GND];
  assign fb_delta = (tank_feedback_i >= cur.prev_fb) ? tank_feedback_i - cur.prev_fb :
                    cur.prev_fb - tank_feedback_i;
  assign step_thr_eff = s[tx_search_pkg::P_THR_HI] ? tx_search_pkg::DEFAULT_STEP_THR :
                        cur.step_thr;
  assign fb_exit = cur.fb_valid & ~s[tx_search_pkg::P_FB_GND] & (fb_delta >= step_thr_eff);
  assign first_step = s[tx_search_pkg::P_PWM_GND] ? tx_search_pkg::FIRST_STEP :
                      (cur.min_step == 5'h00) ? tx_search_pkg::FIRST_STEP :
                      (cur.min_step > tx_search_pkg::MAX_STEP) ? tx_search_pkg::MAX_STEP :
                      cur.min_step;
  // a half period shorter than the limit means the tank looks detuned by metal
  assign freq_fault_now = dir_edge & cur.locked & (cur.half_cnt < cur.freq_limit);
  // width = step/32 of the full period = half period * step / 16
  assign prod = 21'(cur.half_period) * 21'(cur.step);
  assign thr_a = prod[20:4];
  assign thr_b = prod[20:4];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_cur = cur;
    next_cur.sync1 = pins;
    next_cur.sync2 = cur.sync1;
    next_cur.dir_prev = dir;
    next_cur.us_cnt = tick ? 7'h00 : cur.us_cnt + 7'h01;
    if (tick && cur.tmr != 24'hFFFFFF) begin
      next_cur.tmr = cur.tmr + 24'h000001;
    end

    // wishbone slave, one wait state, unmapped reads zero
    next_cur.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !cur.ack) begin
      next_cur.ack = 1'b1;
      next_cur.dat = 32'h00000000;
      if (wb_we_i) begin
        case (wb_adr_i)
          tx_search_pkg::OFS_SETTLE: begin
            next_cur.settle_us = settle_wr[15:0];
          end
          tx_search_pkg::OFS_DELAY: begin
            next_cur.delay_us = delay_wr[23:0];
          end
          tx_search_pkg::OFS_SEARCH: begin
            next_cur.min_step = wb_sel_i[0] ? wb_dat_i[tx_search_pkg::MIN_STEP_LSB +: 5] :
                                cur.min_step;
            next_cur.step_thr = wb_sel_i[1] ? wb_dat_i[tx_search_pkg::STEP_THR_LSB +: 8] :
                                cur.step_thr;
          end
          tx_search_pkg::OFS_FREQ: begin
            next_cur.freq_limit = freq_wr[15:0];
          end
          default: begin
          end
        endcase
      end else begin
        case (wb_adr_i)
          tx_search_pkg::OFS_SETTLE: next_cur.dat = {16'h0000, cur.settle_us};
          tx_search_pkg::OFS_DELAY: next_cur.dat = {8'h00, cur.delay_us};
          tx_search_pkg::OFS_SEARCH: next_cur.dat = {16'h0000, cur.step_thr, 3'h0,
                                                     cur.min_step};
          tx_search_pkg::OFS_FREQ: next_cur.dat = {16'h0000, cur.freq_limit};
          tx_search_pkg::OFS_STATUS: next_cur.dat = {cur.half_period, 3'h0, cur.step, 1'b0,
                                                     cur.locked, cur.ilim_flag, cur.no_rx,
                                                     hot_eff, cur.freq_fault,
                                                     cur.state == tx_search_pkg::st_search,
                                                     cur.stat_on};
          default: next_cur.dat = 32'h00000000;
        endcase
      end
    end

    // search sequencer
    case (cur.state)
      tx_search_pkg::st_off: begin
        if (!disabled) begin
          next_cur.state = tx_search_pkg::st_search;
          next_cur.step = first_step;
          next_cur.tmr = 24'h000000;
          next_cur.fb_valid = 1'b0;
          next_cur.freq_fault = 1'b0;
        end
      end
      tx_search_pkg::st_search: begin
        if (disabled) begin
          next_cur.state = tx_search_pkg::st_off;
        end else if (freq_fault_now) begin
          next_cur.state = tx_search_pkg::st_rest;
          next_cur.freq_fault = 1'b1;
          next_cur.tmr = 24'h000000;
        end else if (ith_eff) begin
          next_cur.state = tx_search_pkg::st_hold;
          next_cur.no_rx = 1'b0;
          next_cur.ilim_flag = 1'b0;
          next_cur.tmr = 24'h000000;
        end else if (settle_done) begin
          next_cur.tmr = 24'h000000;
          if (fb_exit) begin
            next_cur.state = tx_search_pkg::st_hold;
            next_cur.no_rx = 1'b0;
            next_cur.ilim_flag = 1'b0;
          end else if (cur.step >= tx_search_pkg::MAX_STEP) begin
            next_cur.state = tx_search_pkg::st_rest;
            next_cur.no_rx = 1'b1;
          end else begin
            next_cur.step = cur.step + 5'h01;
            next_cur.prev_fb = tank_feedback_i;
            next_cur.fb_valid = 1'b1;
          end
        end
      end
      tx_search_pkg::st_hold: begin
        if (disabled) begin
          next_cur.state = tx_search_pkg::st_off;
        end else if (freq_fault_now) begin
          next_cur.state = tx_search_pkg::st_rest;
          next_cur.freq_fault = 1'b1;
          next_cur.tmr = 24'h000000;
        end else if (ilim_eff || delay_done) begin
          // current limit restarts the search at once, even with one-shot delay
          next_cur.state = tx_search_pkg::st_search;
          next_cur.ilim_flag = ilim_eff;
          next_cur.step = first_step;
          next_cur.tmr = 24'h000000;
          next_cur.fb_valid = 1'b0;
          next_cur.freq_fault = 1'b0;
        end
      end
      tx_search_pkg::st_rest: begin
        if (disabled) begin
          next_cur.state = tx_search_pkg::st_off;
        end else if (delay_done) begin
          next_cur.state = tx_search_pkg::st_search;
          next_cur.step = first_step;
          next_cur.tmr = 24'h000000;
          next_cur.fb_valid = 1'b0;
          next_cur.freq_fault = 1'b0;
        end
      end
      default: begin
        next_cur.state = tx_search_pkg::st_off;
      end
    endcase

    // half period measurement from tank current direction changes
    if (dir_edge) begin
      next_cur.half_period = cur.half_cnt;
      next_cur.half_cnt = 16'h0000;
    end else if (cur.half_cnt != 16'hFFFF) begin
      next_cur.half_cnt = cur.half_cnt + 16'h0001;
    end

    // bridge drive
    if (!drive_en) begin
      next_cur.node_a = 1'b0;
      next_cur.node_b = 1'b0;
      next_cur.locked = 1'b0;
      next_cur.pw_cnt = 17'h00000;
      next_cur.su_cnt = 16'h0000;
      next_cur.sq = 1'b0;
    end else if (!cur.locked) begin
      // fixed start-up square wave until the tank rings
      if (cur.su_cnt == 16'(STARTUP_HALF - 1)) begin
        next_cur.su_cnt = 16'h0000;
        next_cur.sq = ~cur.sq;
      end else begin
        next_cur.su_cnt = cur.su_cnt + 16'h0001;
      end
      next_cur.node_a = next_cur.sq;
      next_cur.node_b = ~next_cur.sq;
      next_cur.locked = dir_edge;
    end else begin
      if (dir_edge) begin
        next_cur.pw_cnt = dir ? thr_a : thr_b;
      end else if (cur.pw_cnt != 17'h00000) begin
        next_cur.pw_cnt = cur.pw_cnt - 17'h00001;
      end
      // pulse follows the current sign so a/c or b/d conduct in phase
      next_cur.node_a = dir & (next_cur.pw_cnt != 17'h00000);
      next_cur.node_b = ~dir & (next_cur.pw_cnt != 17'h00000);
    end

    next_cur.stat_on = (next_cur.state == tx_search_pkg::st_hold) & ~hot_eff & ~disabled;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.settle_us <= tx_search_pkg::RST_SETTLE_US;
      cur.delay_us <= tx_search_pkg::RST_DELAY_US;
      cur.min_step <= tx_search_pkg::RST_MIN_STEP;
      cur.step_thr <= tx_search_pkg::RST_STEP_THR;
      cur.freq_limit <= tx_search_pkg::RST_FREQ_LIMIT;
    end else begin
      cur <= next_cur;
    end
  end

  assign wb_dat_o = cur.dat;
  assign wb_ack_o = cur.ack;
  assign switch_node_a_o = cur.node_a;
  assign switch_node_b_o = cur.node_b;
  assign status_o = 1'b0;
  assign status_oe_n_o = ~cur.stat_on;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ith_pause_a: assert property (
    cur.state == tx_search_pkg::st_search && !disabled && !freq_fault_now && ith_eff
    |=> cur.state == tx_search_pkg::st_hold && $stable(cur.step))
    else $error("threshold did not pause search");
  ilim_restart_a: assert property (
    cur.state == tx_search_pkg::st_hold && !disabled && !freq_fault_now && ilim_eff
    |=> cur.state == tx_search_pkg::st_search ##1 !cur.stat_on)
    else $error("current limit did not restart search");
  current_monitor_level_ignore_a: assert property (
    cur.state == tx_search_pkg::st_hold && s[tx_search_pkg::P_CURRENT_MONITOR_LEVEL_GND] && !disabled &&
    !freq_fault_now && !delay_done |=> cur.state == tx_search_pkg::st_hold)
    else $error("grounded monitor still acted");
  hot_halt_a: assert property (
    hot_eff |=> !switch_node_a_o && !switch_node_b_o && status_oe_n_o)
    else $error("drive active while hot");
  disable_low_a: assert property (
    disabled [*2] |=> !switch_node_a_o && !switch_node_b_o && cur.state == tx_search_pkg::st_off)
    else $error("nodes not low while disabled");
  stat_pull_a: assert property (
    !status_oe_n_o |-> $past(cur.state) == tx_search_pkg::st_hold || cur.state ==
    tx_search_pkg::st_hold)
    else $error("status low outside delivery");
  freq_stop_a: assert property (
    freq_fault_now && !disabled && cur.state != tx_search_pkg::st_off &&
    cur.state != tx_search_pkg::st_rest
    |=> cur.state == tx_search_pkg::st_rest && cur.freq_fault ##1 status_oe_n_o)
    else $error("frequency fault did not stop power");
  first_step_a: assert property (
    cur.state == tx_search_pkg::st_off && !disabled && s[tx_search_pkg::P_PWM_GND]
    |=> cur.step == tx_search_pkg::FIRST_STEP)
    else $error("wrong first step");
  step_up_a: assert property (
    cur.state == tx_search_pkg::st_search && !disabled && !freq_fault_now && !ith_eff &&
    settle_done && !fb_exit && cur.step < tx_search_pkg::MAX_STEP
    |=> cur.step == $past(cur.step) + 5'h01)
    else $error("step did not advance");
  no_rx_a: assert property (
    cur.state == tx_search_pkg::st_search && !disabled && !freq_fault_now && !ith_eff &&
    settle_done && !fb_exit && cur.step >= tx_search_pkg::MAX_STEP
    |=> cur.no_rx && cur.state == tx_search_pkg::st_rest ##1 status_oe_n_o)
    else $error("no receiver not reported");
  one_shot_a: assert property (
    cur.state == tx_search_pkg::st_rest && s[tx_search_pkg::P_DLY_GND] && !disabled
    |=> cur.state == tx_search_pkg::st_rest)
    else $error("search repeated with grounded delay");
  bridge_excl_a: assert property (
    cur.locked && switch_node_a_o |-> !switch_node_b_o)
    else $error("both nodes high while locked");

  hold_reached_c: cover property (cur.state == tx_search_pkg::st_search ##1
                                  cur.state == tx_search_pkg::st_hold);
  no_rx_c: cover property (cur.no_rx && cur.state == tx_search_pkg::st_rest);
  freq_fault_c: cover property (cur.freq_fault);
  ilim_c: cover property (cur.ilim_flag && cur.state == tx_search_pkg::st_search);

endmodule

// ==== tb/tank_model.sv ====
// behavioural series lc tank and receiver seen from the switch nodes
`timescale 1ns/1ps

module tank_model (
  input wire logic clk_i,
  input wire logic node_a_i,
  input wire logic node_b_i,
  input wire logic [15:0] half_i,
  input wire logic fb_jump_i,
  output logic dir_o,
  output logic [7:0] fb_o
);
  logic [15:0] cnt = 16'h0000;
  logic [17:0] idle = 18'h00000;
  logic active = 1'b0;
  logic dir = 1'b0;
  assign dir_o = dir;
  // tank rings while driven and for about four half periods after; it stands still once the bridge stays idle longer
  always_ff @(posedge clk_i) begin
    idle <= (node_a_i | node_b_i) ? 18'h00000 : idle + 18'h00001;
    if (node_a_i | node_b_i) active <= 1'b1;
    else if (idle > {half_i, 2'b00}) active <= 1'b0;
    cnt <= (active && cnt < half_i - 16'h0001) ? cnt + 16'h0001 : 16'h0000;
    if (active && cnt >= half_i - 16'h0001) dir <= ~dir;
  end
  // rectified peak: the receiver load shows as a jump the bench commands
  assign fb_o = fb_jump_i ? 8'h90 : 8'h20;
endmodule

// ==== tb/wireless_tx_power_search_ctrl_bench.sv ====
// self-checking bench of the transmit power search controller
`timescale 1ns/1ps

module wireless_tx_power_search_ctrl_bench;
  logic clk_i, rst_i, cyc, stb, we, ith, ilim, mon_gnd, hot, ntc_open, dis, fb_gnd, jump;
  logic dly_gnd, dly_open, pwm_gnd, thr_hi;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] half;
  logic [7:0] fb;
  logic dir, stat_pin;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, node_a, node_b, status_o, status_oe_n_o;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  tx_search_ctrl #(.STARTUP_HALF(50), .DEFAULT_DELAY(20)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .search_current_threshold_i(ith), .delay_current_limit_i(ilim),
    .current_monitor_grounded_i(mon_gnd), .thermistor_hot_i(hot), .thermistor_open_i(ntc_open),
    .disable_i(dis), .settle_cap_tied_high_i(1'b0), .search_delay_cap_grounded_i(dly_gnd),
    .search_delay_cap_open_i(dly_open), .tank_feedback_grounded_i(fb_gnd),
    .min_pulse_width_grounded_i(pwm_gnd), .feedback_step_tied_high_i(thr_hi),
    .tank_current_dir_i(dir), .tank_feedback_i(fb), .switch_node_a_o(node_a),
    .switch_node_b_o(node_b), .status_o(status_o), .status_oe_n_o(status_oe_n_o));
  tank_model tank (.clk_i(clk_i), .node_a_i(node_a), .node_b_i(node_b), .half_i(half),
    .fb_jump_i(jump), .dir_o(dir), .fb_o(fb));
  // open drain status with board pull-up
  assign stat_pin = status_oe_n_o ? 1'b1 : status_o;
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // classic cycle: hold until ack is seen at an edge, take data and release at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_stat(input logic exp, input int lim, input string name);
    int n = 0;
    while (stat_pin !== exp && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk(name, stat_pin, exp);
  endtask
  task automatic hold_stat(input logic exp, input int len, input string name);
    int bad = 0;
    repeat (len) begin
      @(negedge clk_i);
      if (stat_pin !== exp || (exp && (node_a | node_b) !== 1'b0 && dis)) bad++;
    end
    chk(name, bad, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0); chk("settle reset", rdat, 32'h0000_03E8);
    wb(1'b0, 8'h20, 32'h0); chk("unmapped read", rdat, 32'h0);
    wb(1'b1, 8'h00, 32'h2); wb(1'b1, 8'h04, 32'h5);
    wb(1'b0, 8'h04, 32'h0); chk("delay readback", rdat, 32'h5);
    $display("test regs done");
  endtask
  task automatic t_fb_exit();
    @(posedge clk_i) dis <= 1'b0;
    repeat (600) @(posedge clk_i);
    jump <= 1'b1;
    wait_stat(1'b0, 2000, "fb exit status");
    wb(1'b0, 8'h10, 32'h0); chk("delivering bit", rdat[0], 1'b1);
    @(posedge clk_i) ilim <= 1'b1;
    wait_stat(1'b1, 6, "limit stop");
    @(posedge clk_i) ilim <= 1'b0;
    $display("test feedback exit done");
  endtask
  task automatic t_no_rx();
    int n = 0;
    @(posedge clk_i) fb_gnd <= 1'b1;
    jump <= 1'b0;
    hold_stat(1'b1, 4500, "grounded feedback");
    do begin
      wb(1'b0, 8'h10, 32'h0);
      n++;
    end while (rdat[4] !== 1'b1 && n < 50);
    chk("no receiver bit", rdat[4], 1'b1);
    $display("test no receiver done");
  endtask
  task automatic t_current();
    @(posedge clk_i) mon_gnd <= 1'b1;
    ith <= 1'b1;
    hold_stat(1'b1, 1500, "monitor grounded");
    @(posedge clk_i) mon_gnd <= 1'b0;
    wait_stat(1'b0, 8000, "threshold hold");
    $display("test current done");
  endtask
  task automatic t_hot();
    // long delay so a re-search cannot flicker status during the thermal checks
    wb(1'b1, 8'h04, 32'h64);
    @(posedge clk_i) hot <= 1'b1;
    repeat (4) @(negedge clk_i);
    wait_stat(1'b1, 1, "hot halt");
    repeat (2) @(negedge clk_i);
    chk("hot nodes", {node_a, node_b}, 2'b00);
    @(posedge clk_i) hot <= 1'b0;
    wait_stat(1'b0, 8000, "hot resume");
    @(posedge clk_i) ntc_open <= 1'b1;
    hot <= 1'b1;
    hold_stat(1'b0, 500, "thermistor open");
    @(posedge clk_i) hot <= 1'b0;
    ntc_open <= 1'b0;
    $display("test thermal done");
  endtask
  task automatic t_freq_dis();
    @(posedge clk_i) half <= 16'h00C8;
    wait_stat(1'b1, 2000, "freq fault status");
    wb(1'b0, 8'h10, 32'h0); chk("freq fault bit", rdat[2], 1'b1);
    @(posedge clk_i) half <= 16'h012C;
    dis <= 1'b1;
    repeat (4) @(posedge clk_i);
    hold_stat(1'b1, 300, "disabled nodes");
    $display("test frequency and disable done");
  endtask
  task automatic t_pins();
    wb(1'b1, 8'h04, 32'h5);
    wb(1'b1, 8'h08, 32'h0000_FF04);
    @(posedge clk_i) pwm_gnd <= 1'b1;
    dly_open <= 1'b1;
    dis <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0);
    chk("grounded width step", rdat[12:8], 32'h1);
    // register delay is short, so only the default keeps this hold unbroken
    hold_stat(1'b0, 1500, "open delay default");
    @(posedge clk_i) dly_gnd <= 1'b1;
    dly_open <= 1'b0;
    hold_stat(1'b0, 1500, "grounded delay one shot");
    @(posedge clk_i) pwm_gnd <= 1'b0;
    fb_gnd <= 1'b0;
    thr_hi <= 1'b1;
    @(posedge clk_i) ilim <= 1'b1;
    ith <= 1'b0;
    repeat (4) @(posedge clk_i);
    ilim <= 1'b0;
    wb(1'b0, 8'h10, 32'h0);
    chk("divider width step", rdat[12:8], 32'h4);
    // programmed threshold 0xFF would never exit; the tied default must
    repeat (600) @(posedge clk_i);
    jump <= 1'b1;
    wait_stat(1'b0, 2000, "tied step threshold");
    $display("test pin straps done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, ith, ilim, mon_gnd, hot, ntc_open, fb_gnd, jump} = '0;
    {adr, wdat} = '0;
    {dly_gnd, dly_open, pwm_gnd, thr_hi} = '0;
    half = 16'h012C;
    dis = 1'b1;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_fb_exit();
    t_no_rx();
    t_current();
    t_hot();
    t_freq_dis();
    t_pins();
    final_report();
  end
endmodule
